// File: hw/sim_defs.vh
// Functional notes
// - byte 0 device type is 00, or 7f when the logical unit is invalid
// - invalid unit changes only the type; other bytes as for unit zero
// - peripheral qualifier bits 7-5 of byte 0 read zero, or 011 when the unit is invalid
// - removable medium flag, byte 1 bit 7, always zero
// - device type modifier, byte 1 bits 6-0, always zero
// - european standard version, byte 2 bits 5-3, is zero
// - standards version, byte 2 bits 2-0, is two
// - response data format, byte 3 bits 3-0, is one
// - byte 4 holds full list length, never cut by allocation
// - byte 7 is 08h for linked commands, byte 6 is zero
// - ascii identification fields fill bytes 8 to 55
// - drive not ready: default text in bytes 16-31 and 44-55
// - mode select replaces all earlier selections, from any initiator
// - unit attention to other initiators only if a value changed
// - spin-up loads saved parameters and flags all initiators
// - failed load: defaults restored, sense code parameters changed
// - good load: sense code says drive reset
// - suppress bit in the parameters loaded at spin-up blocks power-on attention
// - save pages flag copies savable current bits to saved table
// - parameter length zero means no data out transfer
// - inquiry data ends at min of allocation and available bytes
//
// constants for the inquiry and mode select responder
// assumes an apb master with 32-bit aligned word accesses
`ifndef SIM_DEFS_VH
`define SIM_DEFS_VH
`define SIM_A_CTRL 8'h00
`define SIM_A_CDB_LO 8'h04
`define SIM_A_CDB_HI 8'h08
`define SIM_A_STATUS 8'h0c
`define SIM_A_UNIT_ATTN 8'h10
`define SIM_A_PARAM_STAGE 8'h14
`define SIM_A_PARAM_CUR 8'h18
`define SIM_A_PARAM_SAVED 8'h1c
`define SIM_A_ID_INDEX 8'h20
`define SIM_A_ID_DATA 8'h24
`define SIM_OP_INQUIRY 8'h12
`define SIM_OP_MODE_SELECT 8'h15
`define SIM_TYPE_DIRECT 8'h00
`define SIM_TYPE_UNKNOWN 8'h7f
`define SIM_INQ_AVAIL 8'h78
`define SIM_INQ_ADD_LEN 8'h73
`define SIM_INQ_BYTE2 8'h02
`define SIM_INQ_BYTE3 8'h01
`define SIM_INQ_BYTE7 8'h08
`define SIM_ID_FIRST 8'h08
`define SIM_ID_LAST 8'h37
`define SIM_DEF_MODEL_FIRST 8'h10
`define SIM_DEF_MODEL_LAST 8'h1f
`define SIM_DEF_SER_FIRST 8'h2c
`define SIM_ID_BYTES 6'h30
`define SIM_STAT_GOOD 8'h00
`define SIM_STAT_CHECK 8'h02
`define SIM_KEY_NONE 4'h0
`define SIM_KEY_ILLEGAL 4'h5
`define SIM_KEY_UNIT_ATTN 4'h6
`define SIM_ASC_NONE 8'h00
`define SIM_ASC_BAD_OP 8'h20
`define SIM_ASC_BAD_FIELD 8'h24
`define SIM_ASC_RESET 8'h29
`define SIM_ASC_PARAM_CHG 8'h2a
`define SIM_PARAM_DEFAULT 32'h0000_0000
`define SIM_PARAM_SAVABLE 32'hffff_fffe
`define SIM_PARAM_NO_UA_BIT 1
`define SIM_CTRL_START 0
`define SIM_CTRL_SPIN 1
`define SIM_CTRL_LOAD_OK 2
`define SIM_SP_BIT 0
`define SIM_IDX_PRELOAD 8'hff
`define SIM_ID_RESET 8'h20
`define SIM_POS_TYPE 8'h00
`define SIM_POS_MOD 8'h01
`define SIM_POS_VER 8'h02
`define SIM_POS_FMT 8'h03
`define SIM_POS_LEN 8'h04
`define SIM_POS_LINK 8'h07
`endif

// File: hw/sim_responder.v
// inquiry builder and mode select decoder for a direct-access target
// assumes firmware loads the command block over apb and drains the
// inquiry bytes on the data-in handshake port on the same clock
// read data is registered in the setup cycle of each apb transfer
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "sim_defs.vh"
module sim_responder (
  input wire pclk, // device clock, 25 mhz
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb write
  input wire [7:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output wire pready, // apb ready, always one
  output reg pslverr, // apb error on unmapped address
  input wire drive_ready_pin, // spindle ready, from outside
  output wire din_valid, // inquiry byte valid
  input wire din_ready, // inquiry byte taken
  output reg [7:0] din_data_q, // inquiry byte
  output reg [7:0] dout_len_q, // bytes expected in data out
  output reg dout_req_q // data out phase wanted
);
  // arbitrary neutral default text, not a real product string
  parameter [127:0] DEF_MODEL = "DISKXXXXXXXXXXXX";
  parameter [95:0] DEF_SERIAL = "No serial ##";

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_INQ = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  // ************************************************************
  // apb decode
  // ************************************************************
  wire wr_en = psel & penable & pwrite;
  reg hit;
  reg [31:0] rd_mux;
  reg [2:0] state_q;
  reg [31:0] cdb_lo_q;
  reg [15:0] cdb_hi_q;
  reg [2:0] init_id_q;
  reg [7:0] ua_q;
  reg [7:0] ua_asc_q;
  reg [31:0] stage_q;
  reg [31:0] cur_q;
  reg [31:0] saved_q;
  reg [5:0] id_idx_q;
  reg [7:0] id_mem [0:47];
  reg [7:0] stat_q;
  reg [3:0] key_q;
  reg [7:0] asc_q;
  reg [7:0] idx_q;
  reg [7:0] cnt_q;
  reg not_ready_q;
  reg rdy_s1_q;
  reg rdy_s2_q;
  integer i;

  assign pready = 1'b1;
  assign din_valid = state_q[1];

  always @* begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `SIM_A_CTRL: rd_mux = {25'h0, init_id_q, 4'h0};
      `SIM_A_CDB_LO: rd_mux = cdb_lo_q;
      `SIM_A_CDB_HI: rd_mux = {16'h0, cdb_hi_q};
      `SIM_A_STATUS: rd_mux = {dout_len_q, asc_q, key_q, 1'b0,
        rdy_s2_q, state_q[0], state_q[2], stat_q};
      `SIM_A_UNIT_ATTN: rd_mux = {16'h0, ua_asc_q, ua_q};
      `SIM_A_PARAM_STAGE: rd_mux = stage_q;
      `SIM_A_PARAM_CUR: rd_mux = cur_q;
      `SIM_A_PARAM_SAVED: rd_mux = saved_q;
      `SIM_A_ID_INDEX: rd_mux = {26'h0, id_idx_q};
      `SIM_A_ID_DATA: rd_mux = {24'h0, id_mem[id_idx_q]};
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // apb read data
  // ************************************************************
  // caught in the setup cycle and held through the access phase;
  // a status bit that moves in between shows on the next poll,
  // which firmware loops on anyway
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rd_mux;
    end
  end

  // ************************************************************
  // ready pin synchroniser
  // ************************************************************
  // the level is taken only at command start, so a drive that turns
  // ready mid-stream still gets default text for that one inquiry
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
    end else begin
      rdy_s1_q <= drive_ready_pin;
      rdy_s2_q <= rdy_s1_q;
    end
  end

  // ************************************************************
  // command block fields
  // ************************************************************
  wire [7:0] opcode = cdb_lo_q[7:0];
  wire [7:0] cdb1 = cdb_lo_q[15:8];
  wire [7:0] cdb2 = cdb_lo_q[23:16];
  wire [7:0] cdb3 = cdb_lo_q[31:24];
  wire [7:0] cdb4 = cdb_hi_q[7:0];
  wire [7:0] cdb5 = cdb_hi_q[15:8];
  wire lun_bad = |cdb1[7:5];
  // flag and link bits of byte 5 are allowed, the rest is reserved
  wire ctl_bad = |cdb5[7:2];
  wire inq_bad = (|cdb1[4:0]) | (|cdb2) | (|cdb3) | ctl_bad;
  wire ms_bad = (|cdb1[4:1]) | (|cdb2) | (|cdb3) | ctl_bad;
  wire ctrl_wr = wr_en & (paddr == `SIM_A_CTRL);
  wire start_w = ctrl_wr & pwdata[`SIM_CTRL_START];
  wire spinup_w = ctrl_wr & pwdata[`SIM_CTRL_SPIN];
  wire load_ok_w = pwdata[`SIM_CTRL_LOAD_OK];
  wire ua_clr_w = wr_en & (paddr == `SIM_A_UNIT_ATTN);
  wire [7:0] inq_len = (cdb4 < `SIM_INQ_AVAIL) ? cdb4 :
                       `SIM_INQ_AVAIL;
  wire [7:0] self_bit = 8'h01 << init_id_q;
  wire param_diff = (stage_q != cur_q);
  wire [31:0] powerup_val = load_ok_w ? saved_q : `SIM_PARAM_DEFAULT;

  // ************************************************************
  // inquiry byte builder
  // ************************************************************
  reg [7:0] inq_byte;
  reg [7:0] nidx;
  reg [7:0] didx;
  reg [7:0] ridx;

  always @* begin
    nidx = idx_q + 8'h01;
    inq_byte = 8'h00;
    didx = 8'h00;
    ridx = 8'h00;
    if (nidx == `SIM_POS_TYPE) begin
      // qualifier bits 7-5 are zero in code 00 and 011 in code 7f
      inq_byte = lun_bad ? `SIM_TYPE_UNKNOWN : `SIM_TYPE_DIRECT;
    end else if (nidx == `SIM_POS_MOD) begin
      inq_byte = 8'h00;
    end else if (nidx == `SIM_POS_VER) begin
      inq_byte = `SIM_INQ_BYTE2;
    end else if (nidx == `SIM_POS_FMT) begin
      inq_byte = `SIM_INQ_BYTE3;
    end else if (nidx == `SIM_POS_LEN) begin
      inq_byte = `SIM_INQ_ADD_LEN;
    end else if (nidx == `SIM_POS_LINK) begin
      inq_byte = `SIM_INQ_BYTE7;
    end else if (nidx >= `SIM_ID_FIRST && nidx <= `SIM_ID_LAST) begin
      ridx = nidx - `SIM_ID_FIRST;
      inq_byte = id_mem[ridx[5:0]];
      if (not_ready_q) begin
        if (nidx >= `SIM_DEF_MODEL_FIRST &&
            nidx <= `SIM_DEF_MODEL_LAST) begin
          didx = `SIM_DEF_MODEL_LAST - nidx;
          inq_byte = DEF_MODEL[didx*8 +: 8];
        end else if (nidx >= `SIM_DEF_SER_FIRST) begin
          didx = `SIM_ID_LAST - nidx;
          inq_byte = DEF_SERIAL[didx*8 +: 8];
        end
      end
    end
  end

  // first byte is loaded in the fill cycle, so the builder looks one ahead;
  // idx_q of ff makes nidx point at byte zero
  // ************************************************************
  // command sequencer
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      idx_q <= `SIM_IDX_PRELOAD;
      cnt_q <= 8'h00;
      din_data_q <= 8'h00;
      not_ready_q <= 1'b0;
      stat_q <= `SIM_STAT_GOOD;
      key_q <= `SIM_KEY_NONE;
      asc_q <= `SIM_ASC_NONE;
      dout_len_q <= 8'h00;
      dout_req_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          idx_q <= `SIM_IDX_PRELOAD;
          if (start_w) begin
            stat_q <= `SIM_STAT_GOOD;
            key_q <= `SIM_KEY_NONE;
            asc_q <= `SIM_ASC_NONE;
            dout_len_q <= 8'h00;
            dout_req_q <= 1'b0;
            state_q <= ST_DONE;
            if (opcode == `SIM_OP_INQUIRY) begin
              if (inq_bad) begin
                stat_q <= `SIM_STAT_CHECK;
                key_q <= `SIM_KEY_ILLEGAL;
                asc_q <= `SIM_ASC_BAD_FIELD;
              end else if (inq_len != 8'h00) begin
                not_ready_q <= ~rdy_s2_q;
                cnt_q <= inq_len;
                state_q <= ST_INQ;
              end
            end else if (opcode == `SIM_OP_MODE_SELECT) begin
              if (ms_bad) begin
                stat_q <= `SIM_STAT_CHECK;
                key_q <= `SIM_KEY_ILLEGAL;
                asc_q <= `SIM_ASC_BAD_FIELD;
              end else begin
                dout_len_q <= cdb4;
                dout_req_q <= (cdb4 != 8'h00);
              end
            end else begin
              stat_q <= `SIM_STAT_CHECK;
              key_q <= `SIM_KEY_ILLEGAL;
              asc_q <= `SIM_ASC_BAD_OP;
            end
          end
        end
        ST_INQ: begin
          // fill cycle ignores din_ready: the byte register is still empty
          if (idx_q == `SIM_IDX_PRELOAD) begin
            din_data_q <= inq_byte;
            idx_q <= 8'h00;
          end else if (din_ready) begin
            if (cnt_q == 8'h01) begin
              state_q <= ST_DONE;
            end else begin
              din_data_q <= inq_byte;
              idx_q <= nidx;
            end
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ST_DONE: begin
          // holds until firmware drops the start bit by a ctrl write
          if (ctrl_wr && !pwdata[`SIM_CTRL_START]) begin
            state_q <= ST_IDLE;
            dout_req_q <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // parameter tables and unit attention
  // ************************************************************
  wire ms_exec = start_w & state_q[0] & (opcode == `SIM_OP_MODE_SELECT) &
                 ~ms_bad;
  reg [7:0] ua_set;
  reg [31:0] cur_d;

  always @* begin
    ua_set = 8'h00;
    cur_d = cur_q;
    if (ms_exec) begin
      cur_d = stage_q;
      if (param_diff) begin
        // the sender of the change needs no attention of its own
        ua_set = ~self_bit;
      end
    end else if (spinup_w) begin
      cur_d = powerup_val;
      if (!powerup_val[`SIM_PARAM_NO_UA_BIT]) begin
        ua_set = 8'hff;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_id_q <= 3'h0;
      cdb_lo_q <= 32'h0000_0000;
      cdb_hi_q <= 16'h0000;
      stage_q <= `SIM_PARAM_DEFAULT;
      cur_q <= `SIM_PARAM_DEFAULT;
      saved_q <= `SIM_PARAM_DEFAULT;
      ua_q <= 8'h00;
      ua_asc_q <= `SIM_ASC_NONE;
      id_idx_q <= 6'h00;
      for (i = 0; i < 48; i = i + 1) begin
        id_mem[i] <= `SIM_ID_RESET;
      end
    end else begin
      cur_q <= cur_d;
      // set wins over a simultaneous write-one-to-clear
      ua_q <= (ua_clr_w ? (ua_q & ~pwdata[7:0]) : ua_q) | ua_set;
      if (ms_exec && param_diff) begin
        ua_asc_q <= `SIM_ASC_PARAM_CHG;
      end else if (spinup_w) begin
        ua_asc_q <= load_ok_w ? `SIM_ASC_RESET :
                    `SIM_ASC_PARAM_CHG;
      end
      if (ms_exec && cdb1[`SIM_SP_BIT]) begin
        saved_q <= (saved_q & ~`SIM_PARAM_SAVABLE) |
                   (stage_q & `SIM_PARAM_SAVABLE);
      end else if (wr_en && paddr == `SIM_A_PARAM_SAVED) begin
        saved_q <= pwdata;
      end
      if (ctrl_wr) begin
        init_id_q <= pwdata[6:4];
      end
      if (wr_en && paddr == `SIM_A_CDB_LO && state_q[0]) begin
        cdb_lo_q <= pwdata;
      end
      if (wr_en && paddr == `SIM_A_CDB_HI && state_q[0]) begin
        cdb_hi_q <= pwdata[15:0];
      end
      if (wr_en && paddr == `SIM_A_PARAM_STAGE) begin
        stage_q <= pwdata;
      end
      if (wr_en && paddr == `SIM_A_ID_INDEX) begin
        id_idx_q <= pwdata[5:0];
      end else if (wr_en && paddr == `SIM_A_ID_DATA) begin
        id_mem[id_idx_q] <= pwdata[7:0];
        id_idx_q <= (id_idx_q == `SIM_ID_BYTES - 6'h01) ? 6'h00 :
                    id_idx_q + 6'h01;
      end
    end
  end

  // unmapped access answers with an error in the access phase
  always @* begin
    pslverr = psel & penable & ~hit;
  end

endmodule

// File: sim/sim_responder_monitor.sv
// checker for the inquiry byte stream and the data out request
// assumes it is bound to sim_responder and sees its ports only
`timescale 1ns/10ps
module sim_monitor (
  input wire pclk, // clock
  input wire presetn, // reset, active low
  input wire din_valid, // byte valid
  input wire din_ready, // byte taken
  input wire [7:0] din_data_q, // current byte
  input wire [7:0] dout_len_q, // data out length
  input wire dout_req_q // data out wanted
);
  // ****************
  // byte position
  // ****************
  reg fill_q;
  reg [7:0] pos_q;
  // first valid cycle only fills the byte register, so count from the next
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_q <= 1'b0;
      pos_q <= 8'h00;
    end else begin
      fill_q <= din_valid;
      if (!din_valid)
        pos_q <= 8'h00;
      else if (fill_q && din_ready)
        pos_q <= pos_q + 8'h01;
    end
  end
  wire shown = din_valid && fill_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_open;
    $rose(din_valid);
  endsequence
  sequence s_fill;
    din_valid ##1 shown;
  endsequence
  AST_OPEN: assert property (s_open |-> s_fill)
    else $error("stream closed during fill");
  AST_TYPE: assert property (shown && pos_q == 8'h00 |->
    din_data_q == 8'h00 || din_data_q == 8'h7f) else $error("byte 0 bad");
  AST_BYTE1: assert property (shown && pos_q == 8'h01 |->
    din_data_q == 8'h00) else $error("byte 1 bad");
  AST_BYTE2: assert property (shown && pos_q == 8'h02 |->
    din_data_q == 8'h02) else $error("byte 2 bad");
  AST_BYTE3: assert property (shown && pos_q == 8'h03 |->
    din_data_q == 8'h01) else $error("byte 3 bad");
  AST_BYTE4: assert property (shown && pos_q == 8'h04 |->
    din_data_q == 8'h73) else $error("byte 4 bad");
  AST_LINK: assert property (shown && pos_q[7:1] == 7'h03 |->
    din_data_q == (pos_q[0] ? 8'h08 : 8'h00)) else $error("byte 6/7 bad");
  AST_LIMIT: assert property (shown |-> pos_q < 8'h78)
    else $error("stream longer than available data");
  AST_HOLD: assert property (shown && !din_ready |=>
    $stable(din_data_q)) else $error("byte changed while not taken");
  AST_DOUT: assert property ($rose(dout_req_q) |->
    dout_len_q != 8'h00) else $error("data out asked for zero length");
endmodule
bind sim_responder sim_monitor mon (.pclk(pclk), .presetn(presetn),
  .din_valid(din_valid), .din_ready(din_ready), .din_data_q(din_data_q),
  .dout_len_q(dout_len_q), .dout_req_q(dout_req_q));

// File: sim/sim_host_model.sv
// initiator model: drains inquiry bytes in the data-in phase
// assumes the responder's fill cycle comes before the first byte
`timescale 1ns/10ps
module sim_host_model (
  input wire pclk, // clock
  input wire presetn, // reset, active low
  input wire slow, // stall every other cycle
  input wire clear, // forget bytes taken so far
  input wire din_valid, // byte valid
  output reg din_ready, // byte taken
  input wire [7:0] din_data_q // current byte
);
  // ****************
  // capture
  // ****************
  reg fill_q;
  reg [7:0] got [0:127];
  integer n;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_q <= 1'b0;
      din_ready <= 1'b0;
      n <= 0;
    end else begin
      fill_q <= din_valid;
      din_ready <= slow ? ~din_ready : 1'b1;
      if (clear)
        n <= 0;
      else if (din_valid && fill_q && din_ready) begin
        got[n] <= din_data_q;
        n <= n + 1;
      end
    end
  end
endmodule

// File: sim/tb_scsi_inquiry_mode_select.sv
// bench for sim_responder: inquiry data, mode select, spin-up restore
// assumes sim_host_model drains the stream and the checker is bound
`timescale 1ns/10ps
`include "sim_defs.vh"
module tb_scsi_inquiry_mode_select;
  localparam [127:0] MODEL = "DISKXXXXXXXXXXXX";
  localparam [95:0] SERIAL = "No serial ##";
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg rdy_pin = 1'b1;
  reg slow = 1'b0;
  reg clear = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, din_valid, din_ready, dout_req_q;
  wire [7:0] din_data_q, dout_len_q;
  integer errors = 0;
  integer tests_run = 0;
  integer cyc = 0;
  integer i;
  reg [31:0] rd;
  reg er;
  sim_responder #(.DEF_MODEL(MODEL), .DEF_SERIAL(SERIAL)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drive_ready_pin(rdy_pin),
    .din_valid(din_valid), .din_ready(din_ready), .din_data_q(din_data_q),
    .dout_len_q(dout_len_q), .dout_req_q(dout_req_q));
  sim_host_model host (.pclk(pclk), .presetn(presetn), .slow(slow),
    .clear(clear), .din_valid(din_valid), .din_ready(din_ready),
    .din_data_q(din_data_q));
  // ****************
  // clock, timeout, report
  // ****************
  initial begin
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      give_verdict;
    end
  end
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // ****************
  // bus and command tasks
  // ****************
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdchk(input string nm, input [7:0] a, input [31:0] m, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd & m);
    end
  endtask
  // back to idle first, since command bytes are ignored while busy
  task run(input [31:0] lo, input [15:0] hi, input [2:0] id);
    begin
      apb(1'b1, `SIM_A_CTRL, {25'h0, id, 4'h0});
      clear <= 1'b1;
      apb(1'b1, `SIM_A_CDB_LO, lo);
      clear <= 1'b0;
      apb(1'b1, `SIM_A_CDB_HI, {16'h0, hi});
      apb(1'b1, `SIM_A_CTRL, {25'h0, id, 4'h1});
      rd = 32'h0;
      while (rd[8] !== 1'b1) apb(1'b0, `SIM_A_STATUS, 32'h0);
    end
  endtask
  // ****************
  // scenarios
  // ****************
  task t_inquiry;
    begin
      apb(1'b1, `SIM_A_ID_INDEX, 32'h0);
      for (i = 0; i < 48; i = i + 1) apb(1'b1, `SIM_A_ID_DATA, 32'h30 + i);
      slow <= 1'b1;
      run(32'h0000_0012, 16'h00ff, 3'h0);
      slow <= 1'b0;
      chk("count", 32'h78, host.n);
      chk("byte0", 32'h0, host.got[0]);
      chk("byte4", 32'h73, host.got[4]);
      chk("byte6", 32'h0, host.got[6]);
      chk("byte7", 32'h8, host.got[7]);
      for (i = 0; i < 48; i = i + 1) begin
        chk("id", 32'h30 + i, host.got[8 + i]);
      end
      $display("inquiry full done");
    end
  endtask
  task t_lun;
    begin
      run(32'h0000_2012, 16'h0008, 3'h0);
      chk("count", 32'h8, host.n);
      chk("byte0", 32'h7f, host.got[0]);
      chk("byte2", 32'h2, host.got[2]);
      chk("byte4", 32'h73, host.got[4]);
      chk("byte7", 32'h8, host.got[7]);
      $display("invalid unit done");
    end
  endtask
  task t_notready;
    begin
      rdy_pin <= 1'b0;
      run(32'h0000_0012, 16'h0038, 3'h0);
      rdy_pin <= 1'b1;
      chk("ready", 32'h0, rd[10]);
      chk("vendor", 32'h30, host.got[8]);
      for (i = 0; i < 16; i = i + 1) begin
        chk("model", MODEL[127-8*i -: 8], host.got[16 + i]);
      end
      for (i = 0; i < 12; i = i + 1) begin
        chk("serial", SERIAL[95-8*i -: 8], host.got[44 + i]);
      end
      $display("not ready done");
    end
  endtask
  task t_refuse;
    begin
      run(32'h0000_0012, 16'h0000, 3'h0);
      chk("count", 32'h0, host.n);
      run(32'h0001_0012, 16'h0008, 3'h0);
      chk("inq", {12'h245, 8'h02}, {rd[23:12], rd[7:0]});
      chk("count", 32'h0, host.n);
      run(32'h0000_1015, 16'h0000, 3'h0);
      chk("pf", {12'h245, 8'h02}, {rd[23:12], rd[7:0]});
      run(32'h0000_0000, 16'h0000, 3'h0);
      chk("opcode", {12'h205, 8'h02}, {rd[23:12], rd[7:0]});
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h1, er);
      $display("refusals done");
    end
  endtask
  task t_mode;
    begin
      apb(1'b1, `SIM_A_PARAM_STAGE, 32'ha5);
      run(32'h0000_0115, 16'h0000, 3'h2);
      chk("dout", 32'h0, dout_req_q);
      rdchk("cur", `SIM_A_PARAM_CUR, 32'hffffffff, 32'ha5);
      rdchk("saved", `SIM_A_PARAM_SAVED, 32'hffffffff, 32'ha4);
      rdchk("ua", `SIM_A_UNIT_ATTN, 32'hffff, 32'h2afb);
      apb(1'b1, `SIM_A_UNIT_ATTN, 32'hff);
      run(32'h0000_0015, 16'h0004, 3'h3);
      chk("dout", 32'h104, {dout_req_q, dout_len_q});
      rdchk("ua", `SIM_A_UNIT_ATTN, 32'hff, 32'h0);
      apb(1'b1, `SIM_A_PARAM_STAGE, 32'h5a);
      run(32'h0000_0015, 16'h0000, 3'h3);
      rdchk("cur", `SIM_A_PARAM_CUR, 32'hffffffff, 32'h5a);
      rdchk("ua", `SIM_A_UNIT_ATTN, 32'hff, 32'hf7);
      rdchk("saved", `SIM_A_PARAM_SAVED, 32'hffffffff, 32'ha4);
      apb(1'b1, `SIM_A_UNIT_ATTN, 32'hff);
      $display("mode select done");
    end
  endtask
  task t_spin;
    begin
      apb(1'b1, `SIM_A_PARAM_SAVED, 32'h10);
      apb(1'b1, `SIM_A_CTRL, 32'h6);
      rdchk("cur", `SIM_A_PARAM_CUR, 32'hffffffff, 32'h10);
      rdchk("ua", `SIM_A_UNIT_ATTN, 32'hffff, 32'h29ff);
      apb(1'b1, `SIM_A_UNIT_ATTN, 32'hff);
      apb(1'b1, `SIM_A_CTRL, 32'h2);
      rdchk("cur", `SIM_A_PARAM_CUR, 32'hffffffff, 32'h0);
      rdchk("ua", `SIM_A_UNIT_ATTN, 32'hffff, 32'h2aff);
      apb(1'b1, `SIM_A_UNIT_ATTN, 32'hff);
      apb(1'b1, `SIM_A_PARAM_SAVED, 32'h2);
      apb(1'b1, `SIM_A_CTRL, 32'h6);
      rdchk("ua", `SIM_A_UNIT_ATTN, 32'hff, 32'h0);
      $display("spin-up done");
    end
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_inquiry;
    t_lun;
    t_notready;
    t_refuse;
    t_mode;
    t_spin;
    give_verdict;
  end
endmodule
